//--- icsr_pkg.sv
// Constants for the interrupt control and status register block.
//
// Summary of operation
// - One flag per source, hardware set, software clears
// - One enable bit per source gates its request
// - Three-bit priority field per source, eight levels
// - Capture register holds 7-bit vector, 4-bit level
// - Sources map to bits in natural order
// - CPU level is core bit 3 over status 7:5
// - Software may write the three low level bits
// - Software cannot set the level most significant bit
// - Level msb set blocks all user interrupts
// - Low level bits 111 block user interrupts
// - Low level bits read-only while nesting disabled
// - Control one bit 15 disables interrupt nesting
// - Trap events set control one bits 4 to 1
// - Control two bit 15 selects alternate table
// - Control two bit 14 shows disable instruction
// - Polarity bit one means falling edge, else rising
// - Flag register zero follows the fixed source layout
// - Unimplemented bits read as zero
// - Controller register set: controls, flags, enables, more
package icsr_pkg;
  localparam int NSRC = 80;
  localparam int NGRP = 5;
  localparam int NPRI = 20;
  localparam logic [6:0] VEC_BASE = 7'h08;
  // Word indices of the registers, byte address is four times the index.
  localparam logic [5:0] IDX_STATUS = 6'h00;
  localparam logic [5:0] IDX_CORE = 6'h01;
  localparam logic [5:0] IDX_GC1 = 6'h02;
  localparam logic [5:0] IDX_GC2 = 6'h03;
  localparam logic [5:0] IDX_FLAG = 6'h04;
  localparam logic [5:0] IDX_EN = 6'h09;
  localparam logic [5:0] IDX_PRIO = 6'h0e;
  localparam logic [5:0] IDX_CAPT = 6'h22;
  // Field positions.
  localparam int POS_IPL = 5;
  localparam int POS_PRIORITY_LEVEL_MSB = 3;
  localparam int POS_PSV = 2;
  localparam int POS_NEST = 15;
  localparam int POS_TRAP = 1;
  localparam int POS_ALT = 15;
  localparam int POS_IRQ_DISABLE_ACTIVE = 14;
  localparam int POS_EXT0 = 0;
  localparam int POS_EXT1 = 20;
  localparam int POS_EXT2 = 29;
  // Writable bit masks.
  localparam logic [15:0] MSK_STATUS = 16'h01ff;
  localparam logic [15:0] MSK_GC1 = 16'h801e;
  localparam logic [15:0] MSK_GC2 = 16'h8007;
  localparam logic [NSRC-1:0] MSK_SRC = 80'h2003_c200_0020_201f_3fef;
  localparam logic [15:0] RST_VAL = 16'h0000;
  localparam logic [2:0] LVL_TOP = 3'h7;
endpackage

//--- icsr_regs.sv
// Interrupt control and status registers with APB access.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module icsr_regs (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [icsr_pkg::NSRC-1:0] src_event_i,
  input wire logic [2:0] ext_pin_i,
  input wire logic [3:0] trap_event_i,
  input wire logic irq_disable_active_i,
  input wire logic irq_ack_i,
  output logic irq_req_o,
  output logic [6:0] irq_vector_o,
  output logic [3:0] irq_level_o,
  output logic alt_table_select_o,
  output logic nesting_disable_o,
  output logic [3:0] cpu_priority_level_o
);
  import icsr_pkg::*;

  // ****************************************
  // Register storage
  // ****************************************
  logic [15:0] status_ff;
  logic priority_level_msb_ff;
  logic psv_ff;
  logic [15:0] gc1_ff;
  logic [15:0] gc2_ff;
  logic [NSRC-1:0] flag_ff;
  logic [NSRC-1:0] enable_ff;
  logic [NSRC-1:0][2:0] prio_ff;
  logic [6:0] pending_vector_number_ff;
  logic [3:0] pending_level_ff;
  logic [2:0] ext_prev_ff;
  logic [31:0] prdata_ff;

  // ****************************************
  // Bus decode
  // ****************************************
  logic [5:0] idx;
  logic acc;
  logic wr;
  logic hit;
  logic [15:0] wmask;
  logic [15:0] wdat;

  function automatic logic in_range(input logic [5:0] i,
                                    input logic [5:0] base,
                                    input int n);
    in_range = (i >= base) && (int'(i) < int'(base) + n);
  endfunction

  assign idx = paddr_i[7:2];
  assign acc = psel_i & penable_i;
  assign hit = (paddr_i[31:8] == 24'h000000) &&
               (idx <= IDX_CAPT);
  assign wr = acc & pwrite_i & hit;
  assign wmask = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
  assign wdat = pwdata_i[15:0];
  assign pready_o = 1'b1;
  assign pslverr_o = acc & ~hit;

  // ****************************************
  // Source events and edge detection
  // ****************************************
  logic [2:0] ext_edge;
  logic [NSRC-1:0] src_set;
  logic [2:0] cpl_low;
  logic [3:0] cpl;

  assign cpl_low = status_ff[POS_IPL+2:POS_IPL];
  assign cpl = {priority_level_msb_ff, cpl_low};

  // Tracks the pins through reset too, so no false edge follows it.
  always_ff @(posedge ref_clk_i) begin
    ext_prev_ff <= ext_pin_i;
  end

  always_comb begin
    for (int e = 0; e < 3; e++) begin
      // Falling edge when polarity is one, rising otherwise.
      ext_edge[e] = gc2_ff[e] ? (ext_prev_ff[e] & ~ext_pin_i[e]) :
                                (~ext_prev_ff[e] & ext_pin_i[e]);
    end
    src_set = src_event_i;
    src_set[POS_EXT0] = src_event_i[POS_EXT0] | ext_edge[0];
    src_set[POS_EXT1] = src_event_i[POS_EXT1] | ext_edge[1];
    src_set[POS_EXT2] = src_event_i[POS_EXT2] | ext_edge[2];
    src_set = src_set & MSK_SRC;
  end

  // ****************************************
  // Flag, enable and priority registers
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NGRP; g++) begin : g_grp
      always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
          flag_ff[g*16 +: 16] <= RST_VAL;
          enable_ff[g*16 +: 16] <= RST_VAL;
        end else begin
          // Hardware set wins over a software clear in the same cycle.
          if (wr && idx == IDX_FLAG + 6'(g)) begin
            flag_ff[g*16 +: 16] <= ((flag_ff[g*16 +: 16] & ~wmask) |
                                   (wdat & wmask) | src_set[g*16 +: 16]) &
                                   MSK_SRC[g*16 +: 16];
          end else begin
            flag_ff[g*16 +: 16] <= flag_ff[g*16 +: 16] |
                                   src_set[g*16 +: 16];
          end
          if (wr && idx == IDX_EN + 6'(g)) begin
            enable_ff[g*16 +: 16] <= ((enable_ff[g*16 +: 16] & ~wmask) |
                                     (wdat & wmask)) &
                                     MSK_SRC[g*16 +: 16];
          end
        end
      end
    end
    for (g = 0; g < NSRC; g++) begin : g_pri
      always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
          prio_ff[g] <= 3'h0;
        end else if (wr && idx == IDX_PRIO + 6'(g / 4) &&
                     wmask[(g % 4) * 4] && MSK_SRC[g]) begin
          prio_ff[g] <= wdat[(g % 4) * 4 +: 3];
        end
      end
    end
  endgenerate

  // ****************************************
  // Arbitration
  // ****************************************
  logic best_valid;
  logic [2:0] best_prio;
  logic [6:0] best_idx;

  always_comb begin
    best_valid = 1'b0;
    best_prio = 3'h0;
    best_idx = 7'h00;
    for (int s = 0; s < NSRC; s++) begin
      // Lowest index wins among equal priorities.
      if (flag_ff[s] && enable_ff[s] &&
          ({1'b0, prio_ff[s]} > cpl) &&
          (!best_valid || prio_ff[s] > best_prio)) begin
        best_valid = 1'b1;
        best_prio = prio_ff[s];
        best_idx = 7'(s);
      end
    end
    // Level msb set, or low bits at seven, masks every user source.
    if (priority_level_msb_ff || cpl_low == LVL_TOP) begin
      best_valid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      pending_vector_number_ff <= 7'h00;
      pending_level_ff <= 4'h0;
    end else if (best_valid) begin
      pending_vector_number_ff <= best_idx + VEC_BASE;
      pending_level_ff <= {1'b0, best_prio};
    end
  end

  assign irq_req_o = best_valid;
  assign irq_vector_o = pending_vector_number_ff;
  assign irq_level_o = pending_level_ff;

  // ****************************************
  // Status and core control
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      status_ff <= RST_VAL;
    end else if (irq_ack_i && best_valid) begin
      // Nesting disabled raises the level to seven on entry.
      status_ff[POS_IPL+2:POS_IPL] <= gc1_ff[POS_NEST] ? LVL_TOP :
                                      pending_level_ff[2:0];
    end else if (wr && idx == IDX_STATUS) begin
      status_ff[4:0] <= 5'((status_ff[4:0] & ~wmask[4:0]) |
                           (wdat[4:0] & wmask[4:0]));
      if (wmask[8]) begin
        status_ff[8] <= wdat[8];
      end
      if (wmask[POS_IPL] && !gc1_ff[POS_NEST]) begin
        status_ff[POS_IPL+2:POS_IPL] <= wdat[POS_IPL+2:POS_IPL];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      priority_level_msb_ff <= 1'b0;
      psv_ff <= 1'b0;
    end else begin
      if (|trap_event_i) begin
        priority_level_msb_ff <= 1'b1;
      end else if (wr && idx == IDX_CORE && wmask[POS_PRIORITY_LEVEL_MSB] &&
                   !wdat[POS_PRIORITY_LEVEL_MSB]) begin
        priority_level_msb_ff <= 1'b0;
      end
      if (wr && idx == IDX_CORE && wmask[POS_PSV]) begin
        psv_ff <= wdat[POS_PSV];
      end
    end
  end

  // ****************************************
  // Global control registers
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      gc1_ff <= RST_VAL;
      gc2_ff <= RST_VAL;
    end else begin
      if (wr && idx == IDX_GC1) begin
        gc1_ff <= (((gc1_ff & ~wmask) | (wdat & wmask)) |
                   {11'h000, trap_event_i, 1'b0}) & MSK_GC1;
      end else begin
        gc1_ff[POS_TRAP+3:POS_TRAP] <= gc1_ff[POS_TRAP+3:POS_TRAP] |
                                       trap_event_i;
      end
      if (wr && idx == IDX_GC2) begin
        gc2_ff <= ((gc2_ff & ~wmask) | (wdat & wmask)) & MSK_GC2;
      end
    end
  end

  assign alt_table_select_o = gc2_ff[POS_ALT];
  assign nesting_disable_o = gc1_ff[POS_NEST];
  assign cpu_priority_level_o = cpl;

  // ****************************************
  // Read data
  // ****************************************
  logic [15:0] rd;

  always_comb begin
    rd = 16'h0000;
    if (idx == IDX_STATUS) begin
      rd = status_ff;
    end else if (idx == IDX_CORE) begin
      rd[POS_PRIORITY_LEVEL_MSB] = priority_level_msb_ff;
      rd[POS_PSV] = psv_ff;
    end else if (idx == IDX_GC1) begin
      rd = gc1_ff;
    end else if (idx == IDX_GC2) begin
      rd = gc2_ff;
      rd[POS_IRQ_DISABLE_ACTIVE] = irq_disable_active_i;
    end else if (in_range(idx, IDX_FLAG, NGRP)) begin
      rd = flag_ff[int'(idx - IDX_FLAG) * 16 +: 16];
    end else if (in_range(idx, IDX_EN, NGRP)) begin
      rd = enable_ff[int'(idx - IDX_EN) * 16 +: 16];
    end else if (in_range(idx, IDX_PRIO, NPRI)) begin
      for (int k = 0; k < 4; k++) begin
        rd[k*4 +: 3] = prio_ff[int'(idx - IDX_PRIO) * 4 + k];
      end
    end else if (idx == IDX_CAPT) begin
      rd = {4'h0, pending_level_ff, 1'b0, pending_vector_number_ff};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      prdata_ff <= 32'h00000000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_ff <= hit ? {16'h0000, rd} : 32'h00000000;
    end
  end

  assign prdata_o = prdata_ff;
endmodule

//--- icsr_regs_sva.sv
// Port assertions for the interrupt control and status registers.
`timescale 1ns/1ps
module icsr_regs_sva (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [3:0] trap_event_i,
  input wire logic irq_ack_i,
  input wire logic irq_req_o,
  input wire logic [6:0] irq_vector_o,
  input wire logic [3:0] irq_level_o,
  input wire logic nesting_disable_o,
  input wire logic [3:0] cpu_priority_level_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire acc = psel_i && penable_i;
  wire [3:0] cpl = cpu_priority_level_o;
  wire bad = paddr_i[31:8] != 24'h0 || paddr_i[7:2] > 6'h22;
  AST_RDY: assert property (acc |-> pready_o)
    else $error("pready low in access phase");
  AST_SLV: assert property (acc |-> pslverr_o == bad)
    else $error("pslverr does not match address map");
  AST_MSB: assert property (cpl[3] |-> !irq_req_o)
    else $error("request with level msb set");
  AST_TOP: assert property (cpl[2:0] == 3'h7 |-> !irq_req_o)
    else $error("request at level seven");
  AST_LVL: assert property (irq_req_o |=> irq_level_o > $past(cpl))
    else $error("captured level not above cpu level");
  AST_VEC: assert property (irq_req_o |=> irq_vector_o inside {[8:87]})
    else $error("captured vector out of range");
  AST_TRAP: assert property (trap_event_i != 4'h0 |-> ##[1:2] cpl[3])
    else $error("trap did not raise level msb");
  AST_ACK: assert property (irq_ack_i && irq_req_o && !nesting_disable_o
    |=> cpl[2:0] == $past(irq_level_o[2:0]))
    else $error("ack did not load captured level");
  AST_HOLD: assert property (nesting_disable_o && acc && pwrite_i &&
    paddr_i[7:2] == 6'h00 && !irq_ack_i |=> $stable(cpl[2:0]))
    else $error("level bits written while nesting disabled");
  COV_REQ: cover property (irq_req_o);
  COV_ACK: cover property (irq_ack_i && irq_req_o);
  COV_ERR: cover property (pslverr_o);
endmodule
bind icsr_regs icsr_regs_sva u_icsr_regs_sva (.ref_clk_i, .reset_n_i,
  .psel_i, .penable_i, .pwrite_i, .paddr_i, .pready_o, .pslverr_o,
  .trap_event_i, .irq_ack_i, .irq_req_o, .irq_vector_o, .irq_level_o,
  .nesting_disable_o, .cpu_priority_level_o);

//--- icsr_cpu_model.sv
// Behavioural CPU core that accepts the block's interrupt requests.
`timescale 1ns/1ps
module icsr_cpu_model (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic irq_req_i,
  input wire logic ack_en_i,
  output logic irq_ack_o
);
  // Accepts a presented request with a one-cycle pulse.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      irq_ack_o <= 1'b0;
    end else begin
      irq_ack_o <= ack_en_i && irq_req_i && !irq_ack_o;
    end
  end
endmodule

//--- icsr_regs_tb.sv
// Self-checking bench for the interrupt control and status registers.
`timescale 1ns/1ps
module icsr_regs_tb;
  import icsr_pkg::*;
  logic ref_clk_i, reset_n_i, psel_i, penable_i, pwrite_i, pready_o;
  logic pslverr_o, irq_disable_active_i, irq_ack_i, irq_req_o, ack_en, e;
  logic alt_table_select_o, nesting_disable_o;
  logic [31:0] paddr_i, pwdata_i, prdata_o, q;
  logic [NSRC-1:0] src_event_i;
  logic [2:0] ext_pin_i;
  logic [3:0] trap_event_i, irq_level_o, cpu_priority_level_o;
  logic [6:0] irq_vector_o;
  int failures, n_compared;
  icsr_regs u_icsr_regs (.ref_clk_i, .reset_n_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i(4'h3), .prdata_o, .pready_o,
    .pslverr_o, .src_event_i, .ext_pin_i, .trap_event_i,
    .irq_disable_active_i, .irq_ack_i, .irq_req_o, .irq_vector_o,
    .irq_level_o, .alt_table_select_o, .nesting_disable_o,
    .cpu_priority_level_o);
  icsr_cpu_model u_icsr_cpu_model (.ref_clk_i, .reset_n_i,
    .irq_req_i(irq_req_o), .ack_en_i(ack_en), .irq_ack_o(irq_ack_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  task automatic summarize();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic xfer(input logic w, input logic [5:0] i,
                      input logic [15:0] d);
    int k;
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= {24'h0, i, 2'h0};
    pwdata_i <= {16'h0, d};
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 16);
    if (k >= 16) begin
      failures++;
      summarize();
    end
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] i, input logic [15:0] d);
    xfer(1'b1, i, d);
  endtask
  task automatic rd(input logic [5:0] i, input logic [31:0] x);
    xfer(1'b0, i, 16'h0);
    chk($sformatf("reg %h", i), x, q);
  endtask
  initial begin
    {psel_i, penable_i, pwrite_i, irq_disable_active_i, ack_en} = '0;
    {paddr_i, pwdata_i, src_event_i, ext_pin_i, trap_event_i} = '0;
    reset_n_i = 1'b0;
    tick(12);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 14; i++) rd(6'(i), 32'h0);
    wr(IDX_GC1, 16'hffff);
    rd(IDX_GC1, 32'h801e);
    wr(IDX_GC1, 16'h0);
    irq_disable_active_i <= 1'b1;
    wr(IDX_GC2, 16'hffff);
    rd(IDX_GC2, 32'hc007);
    chk("alt_table", 1, alt_table_select_o);
    irq_disable_active_i <= 1'b0;
    wr(IDX_GC2, 16'h0);
    rd(IDX_GC2, 32'h0);
    chk("alt_table", 0, alt_table_select_o);
    wr(IDX_FLAG, 16'hffff);
    rd(IDX_FLAG, 32'h3fef);
    wr(IDX_FLAG, 16'h0);
    @(posedge ref_clk_i);
    src_event_i[3] <= 1'b1;
    @(posedge ref_clk_i);
    src_event_i[3] <= 1'b0;
    rd(IDX_FLAG, 32'h8);
    chk("irq_req", 0, irq_req_o);
    wr(IDX_EN, 16'h8);
    wr(IDX_PRIO, 16'h5000);
    tick(2);
    chk("irq_req", 1, irq_req_o);
    chk("irq_vector", 11, irq_vector_o);
    chk("irq_level", 5, irq_level_o);
    rd(IDX_CAPT, 32'h050b);
    for (int k = 4; k < 8; k++) begin
      wr(IDX_STATUS, 16'(k << 5));
      tick(1);
      chk("irq_req", 32'(k < 5), irq_req_o);
      chk("cpl", k, cpu_priority_level_o);
      rd(IDX_STATUS, 32'(k << 5));
    end
    wr(IDX_STATUS, 16'h80);
    ack_en <= 1'b1;
    tick(4);
    ack_en <= 1'b0;
    rd(IDX_STATUS, 32'ha0);
    rd(IDX_FLAG, 32'h8);
    wr(IDX_GC1, 16'h8000);
    wr(IDX_STATUS, 16'h0);
    rd(IDX_STATUS, 32'ha0);
    chk("nesting", 1, nesting_disable_o);
    wr(IDX_GC1, 16'h0);
    wr(IDX_STATUS, 16'h0);
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk_i);
      trap_event_i[k] <= 1'b1;
      @(posedge ref_clk_i);
      trap_event_i[k] <= 1'b0;
      tick(2);
      chk("irq_req", 0, irq_req_o);
      rd(IDX_GC1, 32'h2 << k);
      wr(IDX_GC1, 16'h0);
      wr(IDX_CORE, 16'h0);
    end
    wr(IDX_CORE, 16'h8);
    rd(IDX_CORE, 32'h0);
    chk("irq_req", 1, irq_req_o);
    wr(IDX_GC1, 16'h8000);
    ack_en <= 1'b1;
    tick(4);
    ack_en <= 1'b0;
    rd(IDX_STATUS, 32'he0);
    wr(IDX_GC1, 16'h0);
    wr(IDX_FLAG, 16'h0);
    ext_pin_i[0] <= 1'b1;
    tick(3);
    rd(IDX_FLAG, 32'h1);
    wr(IDX_GC2, 16'h1);
    wr(IDX_FLAG, 16'h0);
    ext_pin_i[0] <= 1'b0;
    tick(3);
    rd(IDX_FLAG, 32'h1);
    wr(IDX_FLAG, 16'h0);
    ext_pin_i[0] <= 1'b1;
    tick(3);
    rd(IDX_FLAG, 32'h0);
    xfer(1'b0, 6'h23, 16'h0);
    chk("unmapped data", 0, q);
    chk("pslverr", 1, e);
    summarize();
  end
endmodule
